// ==== src/tos_scheduler.sv ====
// Timed output scheduler top: takes entries from the output image,
// queues them and applies each at its microsecond timestamp.
// The status image is registered and so trails the queue by one cycle;
// entries that find the queue full are dropped and flagged, never held.
// Assumes the head module writes image slots in ascending order, slot 0
// first, and supplies a 16-bit microsecond ticker synchronous to i_clk.
`timescale 1ns/1ps
`include "tos_defs.svh"

// What this block does
// - Input image length reads fixed four bytes
// - Output image length fixed per variant
// - Parameter bytes cannot be changed
// - Short image holds five four-byte entries
// - State bits 7/6 drive outputs, 5/4 enable
// - Outputs follow only after enable set
// - Written entries go straight into queue
// - New entries append; pending ones kept
// - Applied entry is removed from queue
// - Entries execute one by one, queue order
// - Status bytes returned in input image
module tos_scheduler
    import tos_pkg::*;
#(
    parameter bit LONG_IMAGE = 1'b0,
    parameter int DEPTH = `TOS_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_slot_wr,
    input wire logic [3:0] i_slot_idx,
    input wire tos_entry_t i_slot_data,
    input wire logic [15:0] i_us_ticker,
    output logic o_slot_ready,
    output logic [1:0] o_do,
    output logic [1:0] o_do_en,
    output tos_status_t o_input_process_image,
    output logic [7:0] o_input_image_length,
    output logic [7:0] o_output_image_length
);

    localparam int SLOTS = LONG_IMAGE ? `TOS_SLOTS_LONG : `TOS_SLOTS_SHORT;
    localparam logic [7:0] OUT_IMG_LEN =
        LONG_IMAGE ? `TOS_OUT_IMG_LEN_LONG : `TOS_OUT_IMG_LEN_SHORT;
    localparam int NW = `TOS_SEQ_NUM_W;

    // Sequence number without its flag bits
    function automatic logic [NW-1:0] seq_num(input logic [7:0] s);
        seq_num = s[NW-1:0];
    endfunction : seq_num

    // True when a is ahead of b by 1 to 31, modulo 64
    function automatic logic seq_ahead(input logic [NW-1:0] a,
                                       input logic [NW-1:0] b);
        logic [NW-1:0] d;
        d = a - b;
        seq_ahead = (d != '0) && (d <= `TOS_SEQ_AHEAD_MAX);
    endfunction : seq_ahead

    // Fixed parameter bytes, no write path exists
    logic [7:0] in_len_ff;
    logic [7:0] out_len_ff;

    // Intake state
    logic skip_ff;
    logic nxt_skip;
    logic [7:0] last_seq_ff;
    logic [7:0] nxt_last_seq;
    logic mark_ff;
    logic ovf_ff;

    // Execution state
    logic [NW-1:0] exec_num_ff;
    logic run_ff;
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic ready_ff;
    tos_status_t status_ff;
    tos_status_t nxt_status;

    // Queue handshake
    logic fifo_in_ready;
    logic head_valid;
    tos_entry_t head;

    // Slot decode
    logic slot_first;
    logic slot_final;
    logic slot_in_range;
    logic skip_now;
    logic slot_marked;
    logic slot_new;
    logic take;
    logic push;
    logic drop;

    // Execution decode
    logic due;
    logic pop;

    // Slot decode: a slot after a marked final entry is stale
    assign slot_first = (i_slot_idx == 4'h0);
    assign slot_final = (i_slot_idx == 4'(SLOTS - 1));
    assign slot_in_range = (i_slot_idx < 4'(SLOTS));
    assign skip_now = slot_first ? 1'b0 : skip_ff;
    assign slot_marked = i_slot_data.seq[`TOS_SEQ_LAST];
    assign slot_new = seq_ahead(seq_num(i_slot_data.seq),
                                seq_num(last_seq_ff));

    // Only entries not yet queued are taken, queued ones stay
    assign take = i_slot_wr && slot_in_range && !skip_now && slot_new;
    assign push = take && fifo_in_ready;
    assign drop = take && !fifo_in_ready;

    // Head is due when the wrapping ticker equals its stamp
    assign due = head_valid && (head.ts_us == i_us_ticker);
    assign pop = due;

    // Last received carries the final mark, explicit or by position
    assign nxt_last_seq = {i_slot_data.seq[7],
                           slot_marked || slot_final,
                           i_slot_data.seq[NW-1:0]};

    // Skip flag restarts at slot 0 and sets after an explicitly marked entry
    assign nxt_skip = skip_now || (slot_in_range && slot_marked);

    // Queue level tracked by store and execution
    assign nxt_count = count_ff + 8'(push) - 8'(pop);

    // Input image contents
    assign nxt_status.last_received_sequence = last_seq_ff;
    assign nxt_status.next_sequence_status =
        {`TOS_NEXT_FLAGS, exec_num_ff + 1'b1};
    assign nxt_status.queue_status = {mark_ff, 4'h0, ovf_ff, run_ff,
                                      !fifo_in_ready};
    assign nxt_status.queued_entry_count = count_ff;

    // Entry queue in the data path
    tos_fifo #(
        .WIDTH($bits(tos_entry_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(take),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_slot_data),
        .o_out_valid(head_valid),
        .i_out_ready(pop),
        .o_out_data(head)
    );

    // Output drivers, updated by each executed entry
    tos_out_stage u_out (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_apply(pop),
        .i_state(head.state),
        .o_do(o_do),
        .o_en(o_do_en)
    );

    // Input image length byte reloads its fixed value every cycle
    always_ff @(posedge i_clk)
    begin
        in_len_ff <= `TOS_IN_IMG_LEN;
    end

    // Output image length byte, fixed by the variant; no write path exists
    always_ff @(posedge i_clk)
    begin
        out_len_ff <= OUT_IMG_LEN;
    end

    // Skip flag follows every slot write and restarts at slot 0
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            skip_ff <= 1'b0;
        end
        else if (i_slot_wr)
        begin
            skip_ff <= nxt_skip;
        end
    end

    // Last received sequence moves only with an entry that was queued
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            last_seq_ff <= `TOS_SEQ_RST;
        end
        else if (push)
        begin
            last_seq_ff <= nxt_last_seq;
        end
    end

    // Explicit final mark (seq bit 6) of the last queued entry, shown in the queue status
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mark_ff <= 1'b0;
        end
        else if (push)
        begin
            mark_ff <= slot_marked;
        end
    end

    // Sticky overflow when an entry finds the queue full
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ovf_ff <= 1'b0;
        end
        else if (drop)
        begin
            ovf_ff <= 1'b1;
        end
    end

    // Number of the entry executed last
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            exec_num_ff <= `TOS_NUM_RST;
        end
        else if (pop)
        begin
            exec_num_ff <= seq_num(head.seq);
        end
    end

    // Run flag: set by the first executed entry, cleared only by reset
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            run_ff <= 1'b0;
        end
        else if (pop)
        begin
            run_ff <= 1'b1;
        end
    end

    // Queue level tracked by store and execution
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            count_ff <= 8'h00;
        end
        else
        begin
            count_ff <= nxt_count;
        end
    end

    // Registered ready copy; one cycle stale against the queue
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            ready_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= fifo_in_ready;
        end
    end

    // Input image register, one cycle behind the state it reports
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            status_ff <= '0;
        end
        else
        begin
            status_ff <= nxt_status;
        end
    end

    assign o_slot_ready = ready_ff;
    assign o_input_process_image = status_ff;
    assign o_input_image_length = in_len_ff;
    assign o_output_image_length = out_len_ff;

endmodule : tos_scheduler

// ==== src/tos_defs.svh ====
// Constants of the timed output scheduler: lengths, slot counts, field
// positions and status bits.
// Assumes inclusion by bare name from any file that needs the figures.
`ifndef TOS_DEFS_SVH
`define TOS_DEFS_SVH

// Fixed parameter bytes
`define TOS_IN_IMG_LEN 8'h04
`define TOS_OUT_IMG_LEN_SHORT 8'h14
`define TOS_OUT_IMG_LEN_LONG 8'h3C

// Entry slots per output image variant
`define TOS_SLOTS_SHORT 5
`define TOS_SLOTS_LONG 15

// Default queue depth in entries
`define TOS_FIFO_DEPTH 16

// Output state byte fields
`define TOS_ST_DO0 7
`define TOS_ST_DO1 6
`define TOS_ST_EN0 5
`define TOS_ST_EN1 4

// Sequence number fields
`define TOS_SEQ_LAST 6
`define TOS_SEQ_NUM_W 6
`define TOS_SEQ_AHEAD_MAX 6'h1F
`define TOS_NEXT_FLAGS 2'h3

// Queue status byte fields
`define TOS_QS_FULL 0
`define TOS_QS_RUN 1
`define TOS_QS_OVF 2
`define TOS_QS_MARK 7

// Reset values
`define TOS_SEQ_RST 8'h00
`define TOS_NUM_RST 6'h00

`endif

// ==== src/tos_pkg.sv ====
// Types shared by the timed output scheduler files.
// Assumes nothing beyond a SystemVerilog compiler.
package tos_pkg;

    // One scheduled entry: state byte, sequence byte, timestamp in us
    typedef struct packed {
        logic [7:0] state;
        logic [7:0] seq;
        logic [15:0] ts_us;
    } tos_entry_t;

    // Input image, byte 0 in the top bits
    typedef struct packed {
        logic [7:0] last_received_sequence;
        logic [7:0] next_sequence_status;
        logic [7:0] queue_status;
        logic [7:0] queued_entry_count;
    } tos_status_t;

endpackage : tos_pkg

// ==== src/tos_fifo.sv ====
// Entry queue with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tos_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic do_push;
    logic do_pop;

    // Pointer advance that wraps at any depth
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    // Handshake decode; full and empty come from the true count
    assign o_in_ready = (count_ff != (AW + 1)'(DEPTH));
    assign o_out_valid = (count_ff != '0);
    assign o_out_data = mem[rd_ptr_ff];
    assign do_push = i_in_valid && o_in_ready;
    assign do_pop = o_out_valid && i_out_ready;
    assign nxt_count = count_ff + (AW + 1)'(do_push) - (AW + 1)'(do_pop);

    // Storage array
    always_ff @(posedge i_clk)
    begin
        if (do_push)
        begin
            mem[wr_ptr_ff] <= i_in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (do_pop)
            begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            count_ff <= nxt_count;
        end
    end

endmodule : tos_fifo

// ==== src/tos_out_stage.sv ====
// Output stage: holds the enables and levels of both digital outputs.
// Assumes one-cycle apply pulses with the state byte valid alongside.
`timescale 1ns/1ps
`include "tos_defs.svh"
module tos_out_stage (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_apply,
    input wire logic [7:0] i_state,
    output logic [1:0] o_do,
    output logic [1:0] o_en
);

    logic [1:0] do_ff;
    logic [1:0] en_ff;
    logic [1:0] nxt_en;
    logic [1:0] nxt_do;

    // Enables first, then levels gated by them
    assign nxt_en = {i_state[`TOS_ST_EN1], i_state[`TOS_ST_EN0]};
    assign nxt_do = nxt_en &
        {i_state[`TOS_ST_DO1], i_state[`TOS_ST_DO0]};

    // Outputs change only on an applied entry
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            do_ff <= 2'h0;
            en_ff <= 2'h0;
        end
        else if (i_apply)
        begin
            en_ff <= nxt_en;
            do_ff <= nxt_do;
        end
    end

    assign o_do = do_ff;
    assign o_en = en_ff;

endmodule : tos_out_stage

// ==== tb/tos_sched_properties.sv ====
// Port checker for the timed output scheduler top.
// Assumes it is bound to tos_scheduler and sees only its ports.
`timescale 1ns/1ps
module tos_sched_properties
    import tos_pkg::*;
#(
    parameter bit LONG_IMAGE = 1'b0,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] o_do,
    input wire logic [1:0] o_do_en,
    input wire tos_status_t o_input_process_image,
    input wire logic [7:0] o_input_image_length,
    input wire logic [7:0] o_output_image_length
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Queued count and next sequence byte taken from the status image
    wire logic [7:0] cnt = o_input_process_image.queued_entry_count;
    wire logic [7:0] nxt = o_input_process_image.next_sequence_status;

    // Status count fell by one: an entry left the queue two edges earlier
    sequence s_pop;
        cnt + 8'h01 == $past(cnt);
    endsequence

    AST_IN_LEN: assert property (o_input_image_length == 8'h04)
        else $error("input length wrong");
    AST_OUT_LEN: assert property (
        o_output_image_length == (LONG_IMAGE ? 8'h3C : 8'h14))
        else $error("output length wrong");
    AST_LEN_FIXED: assert property (
        $stable(o_input_image_length) && $stable(o_output_image_length))
        else $error("length byte moved");
    AST_EN_GATE: assert property ((o_do & ~o_do_en) == 2'h0)
        else $error("disabled output driven");
    AST_COUNT_MAX: assert property (cnt <= DEPTH)
        else $error("count above depth");
    AST_NEXT_FLAGS: assert property (
        !$past(i_sys_rst) && !$past(i_sys_rst, 2) |-> nxt[7:6] == 2'h3)
        else $error("next flags wrong");
    AST_COUNT_STEP: assert property (
        8'(cnt - $past(cnt) + 8'h01) <= 8'h02)
        else $error("count jumped");
    AST_POP_NEXT: assert property (s_pop |-> $changed(nxt))
        else $error("pop without next update");
endmodule : tos_sched_properties

bind tos_scheduler tos_sched_properties #(.LONG_IMAGE(LONG_IMAGE),
    .DEPTH(DEPTH)) u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_do(o_do), .o_do_en(o_do_en),
    .o_input_process_image(o_input_process_image),
    .o_input_image_length(o_input_image_length),
    .o_output_image_length(o_output_image_length));

// ==== tb/tos_head_model.sv ====
// Head module model: the microsecond ticker.
// Assumes one tick per clock; far stamps are reached by loading.
`timescale 1ns/1ps
module tos_head_model (
    input wire logic i_clk,
    input wire logic i_load,
    input wire logic [15:0] i_load_val,
    input wire logic i_hold,
    output logic [15:0] o_us_ticker
);
    // Ticker loads, stalls or counts up with wrap to zero
    always_ff @(posedge i_clk)
    begin
        if (i_load)
        begin
            o_us_ticker <= i_load_val;
        end
        else if (!i_hold)
        begin
            o_us_ticker <= o_us_ticker + 16'h0001;
        end
    end
endmodule : tos_head_model

// ==== tb/timed_output_scheduler_tb.sv ====
// Bench: images, timed execution, ordering, overflow and drain.
// Assumes the head model drives the ticker; the bench writes slots.
`timescale 1ns/1ps
`define CHK(got, exp) \
begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
        mismatches++; \
        $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
end
module timed_output_scheduler_tb
    import tos_pkg::*;
();
    logic clk = 1'b0;
    logic rst;
    logic wr;
    logic ld;
    logic hold;
    logic [3:0] idx;
    logic [15:0] ldv;
    logic [15:0] tick;
    tos_entry_t data;
    tos_entry_t img [5];
    logic rdy;
    logic [1:0] dout;
    logic [1:0] den;
    tos_status_t st;
    logic [7:0] il;
    logic [7:0] ol;
    int mismatches = 0;
    int samples_checked = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    tos_head_model u_head (.i_clk(clk), .i_load(ld), .i_load_val(ldv),
        .i_hold(hold), .o_us_ticker(tick));
    tos_scheduler #(.LONG_IMAGE(1'b0), .DEPTH(16)) dut (.i_clk(clk),
        .i_sys_rst(rst), .i_slot_wr(wr), .i_slot_idx(idx),
        .i_slot_data(data), .i_us_ticker(tick), .o_slot_ready(rdy),
        .o_do(dout), .o_do_en(den), .o_input_process_image(st),
        .o_input_image_length(il), .o_output_image_length(ol));

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic set_slot(int i, logic [7:0] s, q, logic [15:0] t);
        img[i] = {s, q, t};
    endtask : set_slot

    // Slots go in ascending order, one per cycle, slot 0 first
    task automatic put_image(input int n);
        for (int i = 0; i < n; i++)
        begin
            idx = 4'(i);
            data = img[i];
            wr = 1'b1;
            step();
        end
        wr = 1'b0;
        repeat (2) step();
    endtask : put_image

    // Ticker is placed just before the stamp; outputs judged once the status image shows the entry executed
    task automatic fire(input tos_entry_t e);
        int n;
        ldv = e.ts_us - 16'h0003;
        ld = 1'b1;
        step();
        ld = 1'b0;
        n = 0;
        while (st.next_sequence_status !== {2'h3, e.seq[5:0] + 6'h01}
            && n < 20)
        begin
            step();
            n++;
        end
        `CHK(n < 20, 1'b1);
        if (n >= 20)
            tally_and_finish();
        `CHK(dout, {e.state[6] & e.state[4], e.state[7] & e.state[5]});
        `CHK(den, {e.state[4], e.state[5]});
    endtask : fire

    task automatic do_reset;
        wr = 1'b0;
        idx = 4'h0;
        data = '0;
        hold = 1'b0;
        rst = 1'b1;
        ld = 1'b1;
        ldv = 16'h0000;
        repeat (10) step();
        `CHK({il, ol}, 16'h0414);
        rst = 1'b0;
        ld = 1'b0;
        repeat (3) step();
        `CHK(st, 32'h00C10000);
        `CHK(il, 8'h04);
        `CHK(ol, 8'h14);
        `CHK({dout, den}, 4'h0);
        `CHK(rdy, 1'b1);
    endtask : do_reset

    // First entry enables both outputs
    task automatic t_first;
        set_slot(0, 8'h30, 8'h01, 16'h1770);
        set_slot(1, 8'hB0, 8'h02, 16'h30DA);
        set_slot(2, 8'hF0, 8'h03, 16'h86D6);
        set_slot(3, 8'h30, 8'h04, 16'hC176);
        set_slot(4, 8'h70, 8'h05, 16'hD501);
        put_image(5);
        `CHK(st, 32'h45C10005);
        for (int i = 0; i < 4; i++)
            fire(img[i]);
        `CHK(st, 32'h45C50201);
    endtask : t_first

    // New image appends; an earlier stamp behind the head must wait
    task automatic t_append;
        set_slot(0, 8'hF0, 8'h06, 16'h0DAC);
        set_slot(1, 8'hB0, 8'h07, 16'h309B);
        set_slot(2, 8'h30, 8'h08, 16'h4ED9);
        set_slot(3, 8'hB0, 8'h09, 16'h75BC);
        set_slot(4, 8'h30, 8'h0A, 16'h91D2);
        put_image(5);
        `CHK(st, 32'h4AC50206);
        ldv = 16'h0DA9;
        ld = 1'b1;
        step();
        ld = 1'b0;
        repeat (10) step();
        `CHK(st.next_sequence_status, 8'hC5);
        fire({8'h70, 8'h05, 16'hD501});
        for (int i = 0; i < 5; i++)
            fire(img[i]);
        `CHK(st.queued_entry_count, 8'h00);
    endtask : t_append

    // Marked final entry in slot 0; later slots and replays ignored
    task automatic t_last;
        set_slot(0, 8'h00, 8'h4B, 16'h9C40);
        put_image(5);
        `CHK(st, 32'h4BCB8201);
        fire(img[0]);
        `CHK(st, 32'h4BCC8200);
        put_image(5);
        `CHK(st.queued_entry_count, 8'h00);
    endtask : t_last

    // Fill past depth, then drain with the ticker stalled on the stamp
    task automatic t_overflow;
        int n;
        for (int k = 0; k < 17; k++)
        begin
            set_slot(k % 5, 8'h30, 8'(8'h0C + k), 16'h1000);
            if (k % 5 == 4 || k == 16)
                put_image(k % 5 + 1);
        end
        `CHK(st.queued_entry_count, 8'h10);
        `CHK(st.queue_status, 8'h07);
        `CHK(rdy, 1'b0);
        ldv = 16'h1000;
        hold = 1'b1;
        ld = 1'b1;
        step();
        ld = 1'b0;
        n = 0;
        while (st.queued_entry_count !== 8'h00 && n < 40)
        begin
            step();
            n++;
        end
        `CHK(n < 40, 1'b1);
        if (n >= 40)
            tally_and_finish();
        `CHK(st.next_sequence_status, 8'hDC);
        `CHK(st.queue_status, 8'h06);
        `CHK(rdy, 1'b1);
        hold = 1'b0;
        step();
    endtask : t_overflow

    // Main sequence, with a second reset after the last test
    initial
    begin
        do_reset();
        t_first();
        t_append();
        t_last();
        t_overflow();
        do_reset();
        tally_and_finish();
    end
endmodule : timed_output_scheduler_tb
